// [logic/bmd_pkg.sv]
package bmd_pkg;

   // ------------------------------------------------------------
   // widths and constants
   // ------------------------------------------------------------
   localparam int          BMD_WORD_W    = 16;
   localparam int          BMD_BIN_W     = 27;  // holds 99999999
   localparam int          BMD_PROD_W    = 54;  // holds 16 digits
   localparam logic [4:0]  BMD_DIV_LAST  = 5'h1a;  // 27 divide steps
   localparam logic [27:0] BMD_TEN8      = 28'h5f5e100;
   localparam logic [53:0] BMD_WORD_MAX  = 54'h270f;
   localparam logic [53:0] BMD_DWORD_MAX = 54'h5f5e0ff;
   localparam logic        BMD_FLAG_RST  = 1'b0;
   localparam logic [15:0] BMD_WORD_RST  = 16'h0000;
   localparam logic [3:0]  BMD_WE_LOW2   = 4'h3;
   localparam logic [3:0]  BMD_WE_ALL4   = 4'hf;

   typedef enum logic [2:0] {
      BMD_OP_SUB2, BMD_OP_MUL1, BMD_OP_MUL2, BMD_OP_DIV1, BMD_OP_DIV2
   } bmd_op_type;

   typedef enum logic [1:0] {
      BMD_ST_IDLE, BMD_ST_EXEC, BMD_ST_DIV, BMD_ST_FIN
   } bmd_state_type;

   // ------------------------------------------------------------
   // bcd helpers
   // ------------------------------------------------------------
   function automatic logic bmd_bcd_ok(input logic [31:0] b);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (b[i*4 +: 4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   function automatic logic [26:0] bmd_to_bin(input logic [31:0] b);
      logic [26:0] v;
      v = '0;
      for (int i = 7; i >= 0; i--) begin
         v = 27'(v * 27'ha) + 27'(b[i*4 +: 4]);
      end
      return v;
   endfunction

   function automatic logic [63:0] bmd_to_bcd(input logic [53:0] v);
      logic [63:0] d;
      d = '0;
      for (int i = 53; i >= 0; i--) begin
         for (int j = 0; j < 16; j++) begin
            if (d[j*4 +: 4] >= 4'h5) begin
               d[j*4 +: 4] = d[j*4 +: 4] + 4'h3;
            end
         end
         d = {d[62:0], v[i]};
      end
      return d;
   endfunction

endpackage

// [logic/bmd_unit.sv]
// What this block does
// RULE1 - execution condition low: no result write, no flag change, just done
// RULE2 - double subtract: two-word base minus two-word amount minus carry
// RULE3 - negative difference sets carry and stores ten's complement
// RULE4 - any non-bcd source word of subtract, multiply, divide raises fault
// RULE5 - indirect pointer not bcd or past data memory end raises fault
// RULE6 - zero flag on when result is zero, off otherwise; for divides the code tests the quotient only
// RULE7 - single multiply: one word times one word into two result words
// RULE8 - multiplies fault on non-bcd factors and set carry on carry
// RULE9 - multiply turns carry on whenever the result carries
// RULE10 - double multiply: two words times two words into four words
// RULE11 - single divide: quotient to first word, remainder to next
// RULE12 - program keeps both single divide result words in one area
// RULE13 - double divide: quotient to words 0-1, remainder to words 2-3
// RULE14 - double divide by zero raises fault, no quotient
// RULE15 - results go only to writable memory areas, never constants
// RULE16 - constants allowed for subtract and multiply, not double divide
// RULE17 - program builds eight-digit constants with block fill first
// RULE18 - four packed digits a word, lower word least significant
// RULE19 - on fault the result words are not written
// RULE20 - carry is one status bit with separate set and clear
module bmd_unit
   import bmd_pkg::*;
#(
   parameter logic [26:0] DM_LAST = 27'h7cf  // last data memory word
) (
   input  wire logic             clk_in,          // 20 MHz clock
   input  wire logic             reset_in,        // sync reset, high
   input  wire logic             start_in,        // execute pulse
   input  wire logic             cond_in,         // execution condition
   input  wire bmd_pkg::bmd_op_type op_in,        // operation
   input  wire logic [15:0]      src_a0_in,       // first source, low
   input  wire logic [15:0]      src_a1_in,       // first source, high
   input  wire logic [15:0]      src_b0_in,       // second source, low
   input  wire logic [15:0]      src_b1_in,       // second source, high
   input  wire logic             ind_check_in,    // indirect operand used
   input  wire logic [15:0]      ind_ptr_in,      // indirect pointer word
   input  wire logic             set_carry_in,    // set carry pulse
   input  wire logic             clear_carry_in,  // clear carry pulse
   output logic [15:0]           res0_out,        // result word r
   output logic [15:0]           res1_out,        // result word r+1
   output logic [15:0]           res2_out,        // result word r+2
   output logic [15:0]           res3_out,        // result word r+3
   output logic [3:0]            res_we_out,      // per-word write pulse
   output logic                  done_out,        // completion pulse
   output logic                  busy_out,        // operation in flight
   output logic                  carry_out,       // carry flag
   output logic                  fault_out,       // fault flag
   output logic                  zero_out         // zero flag
);
   import bmd_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   bmd_state_type state_r, state_nxt;
   bmd_op_type    op_r, op_nxt;
   logic [31:0]   a_r, a_nxt, b_r, b_nxt;
   logic          ind_bad_r, ind_bad_nxt;
   logic [26:0]   num_r, num_nxt, den_r, den_nxt;
   logic [26:0]   rem_r, rem_nxt, quo_r, quo_nxt;
   logic [4:0]    cnt_r, cnt_nxt;
   logic [15:0]   res_r [4];
   logic [15:0]   res_nxt [4];
   logic [3:0]    we_r, we_nxt;
   logic          done_r, done_nxt, busy_r, busy_nxt;
   logic          carry_r, carry_nxt, fault_r, fault_nxt;
   logic          zero_r, zero_nxt;

   // ------------------------------------------------------------
   // operand decode
   // ------------------------------------------------------------
   logic [26:0] av, bv;
   logic [27:0] bsum, diff;
   logic [53:0] prod;
   logic [63:0] d_res, q_bcd, r_bcd;
   logic        single, bad, neg;
   logic [27:0] rem_t;

   // decoded from the request itself, so the next-state block has no loop
   assign single = (op_in == BMD_OP_MUL1) || (op_in == BMD_OP_DIV1);
   assign av     = bmd_to_bin(a_r);
   assign bv     = bmd_to_bin(b_r);
   assign bsum   = 28'(bv) + 28'(carry_r);
   // RULE4 RULE5 RULE14 fault sources
   assign bad    = !bmd_bcd_ok(a_r) || !bmd_bcd_ok(b_r) || ind_bad_r ||
                   ((op_r == BMD_OP_DIV1 || op_r == BMD_OP_DIV2) &&
                    bv == '0);
   // RULE3 borrow past zero wraps by ten to the eighth
   assign neg    = 28'(av) < bsum;
   assign diff   = neg ? (BMD_TEN8 + 28'(av) - bsum) : (28'(av) - bsum);
   assign prod   = 54'(av) * 54'(bv);
   assign d_res  = (op_r == BMD_OP_SUB2) ? bmd_to_bcd(54'(diff)) :
                   bmd_to_bcd(prod);
   assign q_bcd  = bmd_to_bcd(54'(quo_r));
   assign r_bcd  = bmd_to_bcd(54'(rem_r));
   assign rem_t  = {rem_r, num_r[26]};

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      state_nxt   = state_r;
      op_nxt      = op_r;
      a_nxt       = a_r;
      b_nxt       = b_r;
      ind_bad_nxt = ind_bad_r;
      num_nxt     = num_r;
      den_nxt     = den_r;
      rem_nxt     = rem_r;
      quo_nxt     = quo_r;
      cnt_nxt     = cnt_r;
      res_nxt     = res_r;
      we_nxt      = '0;
      done_nxt    = 1'b0;
      carry_nxt   = carry_r;
      fault_nxt   = fault_r;
      zero_nxt    = zero_r;
      case (state_r)
         BMD_ST_IDLE: begin
            if (start_in && !cond_in) begin
               // RULE1 condition low only reports done
               done_nxt = 1'b1;
            end else if (start_in) begin
               op_nxt    = op_in;
               // RULE18 lower word holds low digits
               a_nxt     = single ? {16'h0000, src_a0_in} :
                                    {src_a1_in, src_a0_in};
               b_nxt     = single ? {16'h0000, src_b0_in} :
                                    {src_b1_in, src_b0_in};
               // RULE5 pointer must be bcd and inside data memory
               ind_bad_nxt = ind_check_in &&
                  (!bmd_bcd_ok({16'h0000, ind_ptr_in}) ||
                   bmd_to_bin({16'h0000, ind_ptr_in}) > DM_LAST);
               state_nxt = BMD_ST_EXEC;
            end else if (set_carry_in) begin
               // RULE20 set and clear of the carry bit
               carry_nxt = 1'b1;
            end else if (clear_carry_in) begin
               carry_nxt = 1'b0;
            end
         end
         BMD_ST_EXEC: begin
            if (bad) begin
               // RULE19 fault leaves result words unwritten
               fault_nxt = 1'b1;
               done_nxt  = 1'b1;
               state_nxt = BMD_ST_IDLE;
            end else if (op_r == BMD_OP_DIV1 || op_r == BMD_OP_DIV2) begin
               num_nxt   = av;
               den_nxt   = bv;
               rem_nxt   = '0;
               quo_nxt   = '0;
               cnt_nxt   = '0;
               state_nxt = BMD_ST_DIV;
            end else begin
               fault_nxt = 1'b0;
               done_nxt  = 1'b1;
               state_nxt = BMD_ST_IDLE;
               // RULE6 zero flag follows the whole result
               zero_nxt = (op_r == BMD_OP_SUB2) ? (diff == '0) :
                          (prod == '0);
               case (op_r)
                  BMD_OP_SUB2: begin
                     // RULE2 RULE3 two-word difference, borrow to carry
                     we_nxt    = BMD_WE_LOW2;
                     carry_nxt = neg;
                  end
                  BMD_OP_MUL1: begin
                     // RULE7 RULE8 RULE9 carry when past one word
                     we_nxt    = BMD_WE_LOW2;
                     carry_nxt = prod > BMD_WORD_MAX;
                  end
                  default: begin
                     // RULE10 RULE9 four words, carry past two words
                     we_nxt    = BMD_WE_ALL4;
                     carry_nxt = prod > BMD_DWORD_MAX;
                  end
               endcase
               // only words named by the write pulse change, others hold
               for (int i = 0; i < 4; i++) begin
                  if (we_nxt[i]) begin
                     res_nxt[i] = d_res[i*16 +: 16];
                  end
               end
            end
         end
         BMD_ST_DIV: begin
            // restoring divide, one quotient bit per cycle
            num_nxt = {num_r[25:0], 1'b0};
            if (rem_t >= 28'(den_r)) begin
               rem_nxt = 27'(rem_t - 28'(den_r));
               quo_nxt = {quo_r[25:0], 1'b1};
            end else begin
               rem_nxt = rem_t[26:0];
               quo_nxt = {quo_r[25:0], 1'b0};
            end
            cnt_nxt = 5'(cnt_r + 5'h01);
            if (cnt_r == BMD_DIV_LAST) begin
               state_nxt = BMD_ST_FIN;
            end
         end
         default: begin
            fault_nxt = 1'b0;
            done_nxt  = 1'b1;
            state_nxt = BMD_ST_IDLE;
            zero_nxt  = (quo_r == '0);
            if (op_r == BMD_OP_DIV1) begin
               // RULE11 quotient then remainder
               res_nxt[0] = q_bcd[15:0];
               res_nxt[1] = r_bcd[15:0];
               we_nxt     = BMD_WE_LOW2;
            end else begin
               // RULE13 quotient in words 0-1, remainder in 2-3
               res_nxt[0] = q_bcd[15:0];
               res_nxt[1] = q_bcd[31:16];
               res_nxt[2] = r_bcd[15:0];
               res_nxt[3] = r_bcd[31:16];
               we_nxt     = BMD_WE_ALL4;
            end
         end
      endcase
      busy_nxt = (state_nxt != BMD_ST_IDLE);
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_r   <= BMD_ST_IDLE;
         op_r      <= BMD_OP_SUB2;
         a_r       <= '0;
         b_r       <= '0;
         ind_bad_r <= 1'b0;
         num_r     <= '0;
         den_r     <= '0;
         rem_r     <= '0;
         quo_r     <= '0;
         cnt_r     <= '0;
         for (int i = 0; i < 4; i++) begin
            res_r[i] <= BMD_WORD_RST;
         end
         we_r      <= '0;
         done_r    <= 1'b0;
         busy_r    <= 1'b0;
         carry_r   <= BMD_FLAG_RST;
         fault_r   <= BMD_FLAG_RST;
         zero_r    <= BMD_FLAG_RST;
      end else begin
         state_r   <= state_nxt;
         op_r      <= op_nxt;
         a_r       <= a_nxt;
         b_r       <= b_nxt;
         ind_bad_r <= ind_bad_nxt;
         num_r     <= num_nxt;
         den_r     <= den_nxt;
         rem_r     <= rem_nxt;
         quo_r     <= quo_nxt;
         cnt_r     <= cnt_nxt;
         res_r     <= res_nxt;
         we_r      <= we_nxt;
         done_r    <= done_nxt;
         busy_r    <= busy_nxt;
         carry_r   <= carry_nxt;
         fault_r   <= fault_nxt;
         zero_r    <= zero_nxt;
      end
   end

   assign res0_out   = res_r[0];
   assign res1_out   = res_r[1];
   assign res2_out   = res_r[2];
   assign res3_out   = res_r[3];
   assign res_we_out = we_r;
   assign done_out   = done_r;
   assign busy_out   = busy_r;
   assign carry_out  = carry_r;
   assign fault_out  = fault_r;
   assign zero_out   = zero_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   logic        exec_ok;
   logic [26:0] res_lo_bin;
   assign exec_ok    = (state_r == BMD_ST_EXEC) && !bad;
   assign res_lo_bin = bmd_to_bin({res_r[1], res_r[0]});

   a_cond_low_idle: assert property ( // RULE1
      state_r == BMD_ST_IDLE && start_in && !cond_in |=>
      done_out && res_we_out == '0 && $stable(carry_out) &&
      $stable(fault_out) && $stable(zero_out))
      else $error("condition low changed state");
   a_sub_tens_comp: assert property ( // RULE3
      exec_ok && op_r == BMD_OP_SUB2 |=>
      (28'(res_lo_bin) + $past(bsum) ==
       (carry_out ? BMD_TEN8 : 28'h0) + 28'($past(av))))
      else $error("subtract result or carry wrong");
   a_bad_bcd_fault: assert property ( // RULE4
      state_r == BMD_ST_EXEC && !bmd_bcd_ok(a_r) |=>
      fault_out && done_out)
      else $error("non-bcd source not faulted");
   a_ptr_fault: assert property ( // RULE5
      state_r == BMD_ST_IDLE && start_in && cond_in && ind_check_in &&
      !bmd_bcd_ok({16'h0000, ind_ptr_in}) |=> ##1 fault_out && done_out)
      else $error("bad pointer not faulted");
   a_fault_no_write: assert property ( // RULE19
      done_out && fault_out |-> res_we_out == '0)
      else $error("result written on fault");
   a_mul1_product: assert property ( // RULE7
      exec_ok && op_r == BMD_OP_MUL1 |=>
      54'(res_lo_bin) == $past(prod) && res_we_out == BMD_WE_LOW2 &&
      carry_out == (res_r[1] != '0))
      else $error("single product wrong");
   a_zero_flag: assert property ( // RULE6
      exec_ok && op_r != BMD_OP_DIV1 && op_r != BMD_OP_DIV2 |=>
      zero_out == (res_r[0] == '0 && res_r[1] == '0 &&
                   (res_we_out == BMD_WE_LOW2 ||
                    (res_r[2] == '0 && res_r[3] == '0))))
      else $error("zero flag wrong");
   a_div_zero_fault: assert property ( // RULE14
      state_r == BMD_ST_EXEC && op_r == BMD_OP_DIV2 && bv == '0 |=>
      fault_out && res_we_out == '0)
      else $error("divide by zero not faulted");
   a_div_latency: assert property ( // RULE13
      exec_ok && op_r == BMD_OP_DIV2 |=> ##28 done_out &&
      res_we_out == BMD_WE_ALL4 && !fault_out)
      else $error("divide not done in 29 cycles");

   c_sub_negative: cover property (
      exec_ok && op_r == BMD_OP_SUB2 && neg);
   c_mul2_carry: cover property (
      exec_ok && op_r == BMD_OP_MUL2 && prod > BMD_DWORD_MAX);
   c_div1_done: cover property (
      state_r == BMD_ST_FIN && op_r == BMD_OP_DIV1);
   c_cond_low: cover property (
      state_r == BMD_ST_IDLE && start_in && !cond_in);

endmodule

// [bench/bmd_mem_model.sv]
module bmd_mem_model (
   input  wire logic        clk_in,    // unit clock
   input  wire logic        reset_in,  // sync reset, high
   input  wire logic [15:0] res0_in,   // result word r
   input  wire logic [15:0] res1_in,   // result word r+1
   input  wire logic [15:0] res2_in,   // result word r+2
   input  wire logic [15:0] res3_in,   // result word r+3
   input  wire logic [3:0]  we_in,     // per-word write pulse
   output logic [63:0]      mem_out    // destination words r..r+3
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] mem_r;
   logic [63:0] mem_nxt;
   // ------------------------------------------------------------
   // destination words
   // ------------------------------------------------------------
   // one writable area
   // the four words sit in one contiguous writable window, no constants
   always_comb begin
      mem_nxt = mem_r;
      if (we_in[0]) mem_nxt[15:0] = res0_in;
      if (we_in[1]) mem_nxt[31:16] = res1_in;
      if (we_in[2]) mem_nxt[47:32] = res2_in;
      if (we_in[3]) mem_nxt[63:48] = res3_in;
   end
   always_ff @(posedge clk_in) begin
      mem_r <= reset_in ? 64'h0 : mem_nxt;
   end
   assign mem_out = mem_r;
endmodule

// [bench/testbench.sv]
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
 num_errors++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import bmd_pkg::*;
   localparam logic [26:0] DM_L = 27'h7cf;
   logic clk_in, reset_in, start_in, cond_in, ind_in, set_in, clr_in;
   bmd_op_type op_in;
   logic [15:0] a0, a1, b0, b1, ptr, r0, r1, r2, r3;
   logic [3:0]  we;
   logic        done, busy, cy, fl, zf;
   logic [63:0] mem;
   logic [15:0] m_res [4];
   logic        m_cy, m_fl, m_zf;
   int          num_errors, n_compared, seed;
   bmd_unit #(.DM_LAST(DM_L)) dut (.clk_in(clk_in), .reset_in(reset_in),
      .start_in(start_in), .cond_in(cond_in), .op_in(op_in),
      .src_a0_in(a0), .src_a1_in(a1), .src_b0_in(b0), .src_b1_in(b1),
      .ind_check_in(ind_in), .ind_ptr_in(ptr), .set_carry_in(set_in),
      .clear_carry_in(clr_in), .res0_out(r0), .res1_out(r1),
      .res2_out(r2), .res3_out(r3), .res_we_out(we), .done_out(done),
      .busy_out(busy), .carry_out(cy), .fault_out(fl), .zero_out(zf));
   bmd_mem_model mdl (.clk_in(clk_in), .reset_in(reset_in),
      .res0_in(r0), .res1_in(r1), .res2_in(r2), .res3_in(r3),
      .we_in(we), .mem_out(mem));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // ------------------------------------------------------------
   // bcd helpers of the reference model
   // ------------------------------------------------------------
   function automatic longint bv(input logic [15:0] w);
      longint v;
      v = 0;
      for (int i = 3; i >= 0; i--) v = v * 10 + w[i*4 +: 4];
      return v;
   endfunction
   function automatic logic ok(input logic [15:0] w);
      ok = 1'b1;
      for (int i = 0; i < 4; i++) if (w[i*4 +: 4] > 4'h9) ok = 1'b0;
   endfunction
   function automatic logic [15:0] dw(input longint v, input int k);
      logic [15:0] w;
      longint      x;
      x = v;
      for (int i = 0; i < k; i++) x = x / 10000;
      x = x % 10000;
      for (int i = 0; i < 4; i++) begin
         w[i*4 +: 4] = 4'(x % 10);
         x = x / 10;
      end
      return w;
   endfunction
   task automatic give_verdict();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // one operation, model then design
   // ------------------------------------------------------------
   task automatic do_op(input bmd_op_type op, input logic c,
      input logic [15:0] x0, x1, y0, y1, input logic ind,
      input logic [15:0] p);
      longint     a, b, v, q;
      logic       dbl, bad;
      logic [3:0] ewe;
      int         lat, n;
      dbl = op inside {BMD_OP_SUB2, BMD_OP_MUL2, BMD_OP_DIV2};
      a = dbl ? bv(x1) * 10000 + bv(x0) : bv(x0);
      b = dbl ? bv(y1) * 10000 + bv(y0) : bv(y0);
      bad = !ok(x0) || !ok(y0) || (dbl && (!ok(x1) || !ok(y1)));
      bad = bad || (ind && (!ok(p) || bv(p) > DM_L));
      if (op inside {BMD_OP_DIV1, BMD_OP_DIV2} && b == 0) bad = 1'b1;
      lat = c ? 2 : 1;
      ewe = (c && !bad) ? (dbl && op != BMD_OP_SUB2 ? 4'hf : 4'h3) : 4'h0;
      if (c && bad) m_fl = 1'b1;
      if (c && !bad) begin
         m_fl = 1'b0;
         case (op)
            BMD_OP_SUB2: begin
               v = a - b - longint'(m_cy);
               m_cy = v < 0;
               if (v < 0) v = v + 100000000;
               m_zf = v == 0;
               m_res[0] = dw(v, 0);
               m_res[1] = dw(v, 1);
            end
            BMD_OP_MUL1, BMD_OP_MUL2: begin
               v = a * b;
               m_cy = v > (dbl ? 99999999 : 9999);
               m_zf = v == 0;
               for (int k = 0; k < 4; k++) if (ewe[k]) m_res[k] = dw(v, k);
            end
            default: begin
               q = a / b;
               v = a % b;
               lat = 30;
               m_zf = q == 0;
               m_res[0] = dw(q, 0);
               m_res[1] = dbl ? dw(q, 1) : dw(v, 0);
               if (dbl) m_res[2] = dw(v, 0);
               if (dbl) m_res[3] = dw(v, 1);
            end
         endcase
      end
      @(posedge clk_in);
      start_in <= 1'b1;
      cond_in <= c;
      op_in <= op;
      {a0, a1, b0, b1, ind_in, ptr} <= {x0, x1, y0, y1, ind, p};
      @(posedge clk_in);
      start_in <= 1'b0;
      #1;
      `CHK("busy after start", c, busy)
      n = 1;
      while (done !== 1'b1 && n < 40) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      if (n >= 40) begin
         num_errors++;
         give_verdict();
      end
      `CHK("latency", lat, n)
      `CHK("write enables", ewe, we)
      `CHK("res0", m_res[0], r0)
      `CHK("res1", m_res[1], r1)
      `CHK("res2", m_res[2], r2)
      `CHK("res3", m_res[3], r3)
      `CHK("carry", m_cy, cy)
      `CHK("fault", m_fl, fl)
      `CHK("zero", m_zf, zf)
      `CHK("busy at done", 1'b0, busy)
      @(posedge clk_in);
      #1;
      `CHK("done pulse", 1'b0, done)
      `CHK("memory", {m_res[3], m_res[2], m_res[1], m_res[0]}, mem)
   endtask
   task automatic carry_op(input logic s, input logic c);
      @(posedge clk_in);
      set_in <= s;
      clr_in <= c;
      @(posedge clk_in);
      set_in <= 1'b0;
      clr_in <= 1'b0;
      if (s | c) m_cy = s;
      #1;
      `CHK("carry bit", m_cy, cy)
   endtask
   initial begin
      seed = $urandom(46);
      {start_in, cond_in, ind_in, set_in, clr_in} = 5'h0;
      op_in = BMD_OP_SUB2;
      {a0, a1, b0, b1, ptr} = 80'h0;
      reset_in = 1'b1;
      {num_errors, n_compared} = 0;
      m_res = '{16'h0, 16'h0, 16'h0, 16'h0};
      {m_cy, m_fl, m_zf} = 3'h0;
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      #1;
      `CHK("reset flags", 4'h0, {cy, fl, zf, busy})
      carry_op(1'b1, 1'b0);
      carry_op(1'b1, 1'b1);
      do_op(BMD_OP_SUB2, 1'b0, 16'h0, 16'h0, 16'h5, 16'h0, 1'b0, 16'h0);
      carry_op(1'b0, 1'b1);
      do_op(BMD_OP_SUB2, 1'b1, 16'h0, 16'h0, 16'h1, 16'h0, 1'b0, 16'h0);
      do_op(BMD_OP_SUB2, 1'b1, 16'h2, 16'h0, 16'h1, 16'h0, 1'b0, 16'h0);
      do_op(BMD_OP_MUL2, 1'b1, 16'h9999, 16'h9999, 16'h9999, 16'h9999,
            1'b0, 16'h0);
      do_op(BMD_OP_MUL1, 1'b1, 16'h9999, 16'h0, 16'h2, 16'h0, 1'b0, 16'h0);
      do_op(BMD_OP_DIV2, 1'b1, 16'h5, 16'h1, 16'h0, 16'h0, 1'b0, 16'h0);
      do_op(BMD_OP_DIV1, 1'b1, 16'h5, 16'h0, 16'h0, 16'h0, 1'b0, 16'h0);
      do_op(BMD_OP_DIV1, 1'b1, 16'h7, 16'h0, 16'h9, 16'h0, 1'b0, 16'h0);
      for (int o = 0; o < 5; o++) begin
         for (int k = 0; k < 4; k++) begin
            do_op(bmd_op_type'(o), 1'b1, k == 0 ? 16'h00a0 : 16'h1,
                  k == 1 ? 16'h0b00 : 16'h1, k == 2 ? 16'hf000 : 16'h1,
                  k == 3 ? 16'h000c : 16'h1, 1'b0, 16'h0);
         end
      end
      // pointer at and past the end
      do_op(BMD_OP_MUL1, 1'b1, 16'h12, 16'h0, 16'h3, 16'h0, 1'b1, 16'h1999);
      do_op(BMD_OP_MUL1, 1'b1, 16'h12, 16'h0, 16'h3, 16'h0, 1'b1, 16'h2000);
      do_op(BMD_OP_MUL1, 1'b1, 16'h12, 16'h0, 16'h3, 16'h0, 1'b1, 16'h00b0);
      repeat (60) begin
         do_op(bmd_op_type'($urandom % 5), ($urandom % 8) != 0,
               dw($urandom % 10000, 0), dw($urandom % 10000, 0),
               dw($urandom % 10000, 0), dw($urandom % 10000, 0),
               ($urandom % 4) == 0, dw($urandom % 2500, 0));
      end
      give_verdict();
   end
endmodule
